// file: logic/pmsq_pkg.sv
package pmsq_pkg;
	// ****************************************************
	// time base and timing counts
	// ****************************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int RTC_HZ = 32_768;
	// smbus quiet wait before a forced reset, nominal of a +/-2 ms window
	localparam int SMB_WAIT_MS = 25;
	localparam int SMB_WAIT_CYC = CLK_HZ / 1000 * SMB_WAIT_MS;
	// power button override: strictly more than this many seconds
	localparam int HOLD_S = 4;
	localparam int HOLD_TICKS = RTC_HZ * HOLD_S + 1;
	// reset button must sit stable this long (least time, rounded up)
	localparam int DEBOUNCE_MS = 16;
	localparam int DEBOUNCE_TICKS = (RTC_HZ * DEBOUNCE_MS + 999) / 1000;
	// suspend warning lead time before the planes drop
	localparam int WARN_US = 10;
	localparam int WARN_CYC = CLK_HZ / 1_000_000 * WARN_US;
	// width of the forced internal reset pulse
	localparam int RST_PULSE_US = 2;
	localparam int RST_PULSE_CYC = CLK_HZ / 1_000_000 * RST_PULSE_US;

	// ****************************************************
	// synchroniser bank bit positions
	// ****************************************************
	localparam int SYNC_W = 7;
	localparam int SB_THERM = 0;
	localparam int SB_TRIP = 1;
	localparam int SB_BTN = 2;
	localparam int SB_RING = 3;
	localparam int SB_RSTBTN = 4;
	localparam int SB_PWRGD = 5;
	localparam int SB_RTC = 6;
	// idle levels: active-low pins high, power good and rtc low
	localparam logic [SYNC_W-1:0] SYNC_IDLE = 7'h1F;

	// ****************************************************
	// sleep levels and sequencer states
	// ****************************************************
	typedef logic [2:0] pmsq_level_t;
	localparam pmsq_level_t LVL_S0 = 3'h0;
	localparam pmsq_level_t LVL_S3 = 3'h3;
	localparam pmsq_level_t LVL_S4 = 3'h4;
	localparam pmsq_level_t LVL_S5 = 3'h5;
	typedef enum logic [1:0] {SEQ_RUN, SEQ_WARN, SEQ_SLEEP} pmsq_seq_e;
endpackage

// file: logic/pmsq_sync_if.sv
`timescale 1ns/1ps
interface pmsq_sync_if;
	logic [pmsq_pkg::SYNC_W-1:0] level;
	modport source (output level);
	modport sink (input level);
endinterface

// file: logic/pmsq_sync_bank.sv
`timescale 1ns/1ps
module pmsq_sync_bank
	import pmsq_pkg::*;
	(
	input wire logic clk_sys_in, // system clock
	input wire logic rst_b_in, // resume-well reset, active low
	input wire logic [SYNC_W-1:0] raw_in, // pins from outside the clock domain
	pmsq_sync_if.source sync_out // two-flop synchronised levels
	);
	// ****************************************************
	// two flops per pin; only the second one is ever read
	// ****************************************************
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi++) begin : g_bit
			logic meta;
			logic held;
			always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					meta <= SYNC_IDLE[gi];
					held <= SYNC_IDLE[gi];
				end else begin
					meta <= raw_in[gi];
					held <= meta;
				end
			end
			assign sync_out.level[gi] = held;
		end
	endgenerate
endmodule

// file: logic/pmsq_hold_timer.sv
`timescale 1ns/1ps
module pmsq_hold_timer
	#(parameter int LIMIT = 16)
	(
	input wire logic clk_sys_in, // system clock
	input wire logic rst_b_in, // resume-well reset, active low
	input wire logic active_in, // condition being timed
	input wire logic tick_in, // one-cycle rtc tick
	output logic done_out // condition held for LIMIT ticks
	);
	localparam int CW = $clog2(LIMIT + 1);
	logic [CW-1:0] count;

	// count rtc ticks while the condition holds; any drop restarts it
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count <= '0;
			done_out <= 1'b0;
		end else if (!active_in) begin
			count <= '0;
			done_out <= 1'b0;
		end else begin
			if (tick_in && (count != CW'(LIMIT))) begin
				count <= count + 1'h1;
			end
			done_out <= (count == CW'(LIMIT));
		end
	end
endmodule

// file: logic/pmsq_sequencer.sv
`timescale 1ns/1ps
// Function
// R1 - thermal alarm held low turns on hardware clock throttling
// R2 - thermal alarm assertion raises a management or control interrupt
// R3 - thermal trip low sends the system straight to S5, no stop grant wait
// R4 - ram plane control active in S3, S4 and S5
// R5 - disk plane control active only in S4 and S5
// R6 - soft-off plane control active only in S5
// R7 - host bus reset asserted whenever core power good is low
// R8 - core power good is synchronised before use
// R9 - board asserts core power good after power and clock stable 1 ms
// R10 - board keeps core power good low at least 3 rtc periods
// R11 - power button press while working raises a sleep request interrupt
// R12 - power button press while sleeping is a wake event
// R13 - button held over 4 s forces S5; then only the button wakes
// R14 - ring indicate wake enable, kept through core power failure
// R15 - reset button is debounced, then forces an internal reset
// R16 - reset waits for smbus idle, at most 25 ms
// R17 - resume-well reset clears all resume plane logic
// R18 - board holds network-well reset 10 ms after resume power valid; the board model drives no network-well reset
// R19 - suspend warning asserted before entering a low power state
// R20 - suspend refresh clock output taken from the rtc clock
// R21 - button hold and reset debounce are timed on rtc ticks
module pmsq_sequencer
	import pmsq_pkg::*;
	#(
	parameter int SMB_WAIT_CYCLES = SMB_WAIT_CYC,
	parameter int HOLD_LIMIT = HOLD_TICKS,
	parameter int DEBOUNCE_LIMIT = DEBOUNCE_TICKS
	)
	(
	input wire logic clk_sys_in, // 10 MHz system clock
	input wire logic rst_b_in, // resume-well reset, active low
	input wire logic thermal_alarm_n_in, // thermal alarm pin, active low
	input wire logic thermal_trip_n_in, // processor thermal trip pin, active low
	input wire logic power_button_n_in, // power button pin, active low
	input wire logic ring_indicate_n_in, // modem ring pin, active low
	input wire logic reset_button_n_in, // system reset button pin, active low
	input wire logic core_power_good_in, // core power good pin, async
	input wire logic rtc_clock_in, // always-running rtc clock pin
	input wire logic smbus_idle_in, // smbus controller reports idle
	input wire logic sleep_request_in, // pulse: software asks for sleep
	input wire logic [2:0] sleep_level_in, // sleep level with the request
	input wire logic ring_wake_enable_wr_in, // pulse: load ring wake enable
	input wire logic ring_wake_enable_in, // new ring wake enable value
	input wire logic thermal_use_smi_in, // thermal event to smi, else sci
	input wire logic button_use_smi_in, // button event to smi, else sci
	output logic sleep_ram_plane_off_n_out, // ram plane control, active low
	output logic sleep_disk_plane_off_n_out, // disk plane control, active low
	output logic soft_off_plane_off_n_out, // soft-off plane control, active low
	output logic suspend_warning_n_out, // low power entry warning, active low
	output logic suspend_refresh_clock_out, // refresh clock for other chips
	output logic host_bus_reset_n_out, // host bus reset, active low
	output logic system_mgmt_interrupt_n_out, // smi pulse, active low
	output logic acpi_control_interrupt_out, // sci pulse, active high
	output logic clock_throttle_out, // hardware clock throttling on
	output logic internal_reset_n_out, // forced internal reset, active low
	output logic wake_event_out, // pulse: wake taken
	output logic [2:0] sleep_state_out, // present sleep level
	output logic button_override_out // power button override in force
	);
	localparam int SCW = $clog2(SMB_WAIT_CYCLES);
	localparam int WCW = $clog2(WARN_CYC);
	localparam int PCW = $clog2(RST_PULSE_CYC);
	localparam logic [SCW-1:0] SMB_LAST = SCW'(SMB_WAIT_CYCLES - 1);
	localparam logic [WCW-1:0] WARN_LAST = WCW'(WARN_CYC - 1);
	localparam logic [PCW-1:0] PULSE_LAST = PCW'(RST_PULSE_CYC - 1);

	// ****************************************************
	// pin synchronisers
	// ****************************************************
	logic [SYNC_W-1:0] raw_pins;
	pmsq_sync_if sync_bus ();

	assign raw_pins[SB_THERM] = thermal_alarm_n_in;
	assign raw_pins[SB_TRIP] = thermal_trip_n_in;
	assign raw_pins[SB_BTN] = power_button_n_in;
	assign raw_pins[SB_RING] = ring_indicate_n_in;
	assign raw_pins[SB_RSTBTN] = reset_button_n_in;
	assign raw_pins[SB_PWRGD] = core_power_good_in;
	assign raw_pins[SB_RTC] = rtc_clock_in;

	// every pin crosses here, power good included [R8]
	pmsq_sync_bank u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.raw_in(raw_pins),
		.sync_out(sync_bus)
	);

	logic therm_n;
	logic trip_n;
	logic btn_n;
	logic ring_n;
	logic rstbtn_n;
	logic pwr_good;
	logic rtc_lvl;
	assign therm_n = sync_bus.level[SB_THERM];
	assign trip_n = sync_bus.level[SB_TRIP];
	assign btn_n = sync_bus.level[SB_BTN];
	assign ring_n = sync_bus.level[SB_RING];
	assign rstbtn_n = sync_bus.level[SB_RSTBTN];
	assign pwr_good = sync_bus.level[SB_PWRGD];
	assign rtc_lvl = sync_bus.level[SB_RTC];

	// ****************************************************
	// edge detection and rtc tick
	// ****************************************************
	logic therm_prev;
	logic btn_prev;
	logic ring_prev;
	logic rtc_prev;
	logic therm_fall;
	logic btn_press;
	logic ring_press;
	logic rtc_tick;

	// previous levels; all return to their idle levels under resume-well reset [R17]
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			therm_prev <= 1'b1;
			btn_prev <= 1'b1;
			ring_prev <= 1'b1;
			rtc_prev <= 1'b0;
		end else begin
			therm_prev <= therm_n;
			btn_prev <= btn_n;
			ring_prev <= ring_n;
			rtc_prev <= rtc_lvl;
		end
	end

	assign therm_fall = therm_prev & ~therm_n;
	assign btn_press = btn_prev & ~btn_n;
	assign ring_press = ring_prev & ~ring_n;
	// the rtc keeps running in every sleep state, so timing rides on it [R21]
	assign rtc_tick = rtc_lvl & ~rtc_prev;

	// ****************************************************
	// rtc-timed button hold and reset debounce
	// ****************************************************
	logic hold_done;
	logic hold_prev;
	logic hold_rise;
	logic reset_deb;
	logic reset_deb_prev;
	logic reset_req;

	// long press detector for the override [R21]
	pmsq_hold_timer #(.LIMIT(HOLD_LIMIT)) u_hold (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.active_in(~btn_n),
		.tick_in(rtc_tick),
		.done_out(hold_done)
	);

	// reset button must stay low a full debounce span [R15] [R21]
	pmsq_hold_timer #(.LIMIT(DEBOUNCE_LIMIT)) u_debounce (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.active_in(~rstbtn_n),
		.tick_in(rtc_tick),
		.done_out(reset_deb)
	);

	assign hold_rise = hold_done & ~hold_prev;
	assign reset_req = reset_deb & ~reset_deb_prev;

	// ****************************************************
	// forced reset with bounded smbus wait
	// ****************************************************
	logic reset_wait;
	logic reset_fire;
	logic [SCW-1:0] smb_count;
	logic [PCW-1:0] pulse_count;

	// fire at once when smbus is quiet, else give up waiting at the bound [R16]
	assign reset_fire = (reset_req | reset_wait) & (smbus_idle_in | (smb_count == SMB_LAST));

	// the pulse only restarts on a new debounced press, never while held
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			hold_prev <= 1'b0;
			reset_deb_prev <= 1'b0;
			reset_wait <= 1'b0;
			smb_count <= '0;
			pulse_count <= '0;
			internal_reset_n_out <= 1'b1;
		end else begin
			hold_prev <= hold_done;
			reset_deb_prev <= reset_deb;
			if (reset_fire) begin
				reset_wait <= 1'b0;
				smb_count <= '0;
				pulse_count <= PULSE_LAST;
				internal_reset_n_out <= 1'b0; // [R15]
			end else begin
				if (reset_req) begin
					reset_wait <= 1'b1;
				end
				if (reset_wait) begin
					smb_count <= smb_count + 1'h1;
				end else begin
					smb_count <= '0;
				end
				if (pulse_count != '0) begin
					pulse_count <= pulse_count - 1'h1;
				end else begin
					internal_reset_n_out <= 1'b1;
				end
			end
		end
	end

	// ****************************************************
	// ring wake enable, resume-well only
	// ****************************************************
	logic ring_wake_enable;
	logic ring_wake;

	// core power loss does not touch this; only resume-well reset or a write of 0 clears it [R14]
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ring_wake_enable <= 1'b0;
		end else if (ring_wake_enable_wr_in) begin
			ring_wake_enable <= ring_wake_enable_in;
		end
	end

	// after an override only the button may wake [R13] [R14]
	assign ring_wake = ring_press & ring_wake_enable & ~button_override_out;

	// ****************************************************
	// sleep sequencer
	// ****************************************************
	pmsq_seq_e state;
	pmsq_level_t target;
	logic [WCW-1:0] warn_count;
	logic level_ok;

	// S1..S5 are legal targets; S0 or undefined codes are ignored
	assign level_ok = (sleep_level_in != LVL_S0) && (sleep_level_in <= LVL_S5);

	// trip beats override beats normal flow; trip held low blocks any wake
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state <= SEQ_RUN;
			target <= LVL_S0;
			warn_count <= '0;
			sleep_state_out <= LVL_S0;
			suspend_warning_n_out <= 1'b1;
			button_override_out <= 1'b0;
			wake_event_out <= 1'b0;
		end else begin
			wake_event_out <= 1'b0;
			if (!trip_n) begin
				state <= SEQ_SLEEP; // [R3]
				sleep_state_out <= LVL_S5;
				suspend_warning_n_out <= 1'b0;
			end else if (hold_rise) begin
				state <= SEQ_SLEEP; // [R13]
				sleep_state_out <= LVL_S5;
				suspend_warning_n_out <= 1'b0;
				button_override_out <= 1'b1;
			end else begin
				case (state)
					SEQ_RUN: begin
						if (sleep_request_in && level_ok) begin
							target <= sleep_level_in;
							warn_count <= '0;
							state <= SEQ_WARN;
							suspend_warning_n_out <= 1'b0; // [R19]
						end
					end
					SEQ_WARN: begin
						if (warn_count == WARN_LAST) begin
							state <= SEQ_SLEEP;
							sleep_state_out <= target;
						end else begin
							warn_count <= warn_count + 1'h1;
						end
					end
					SEQ_SLEEP: begin
						if (btn_press || ring_wake) begin
							state <= SEQ_RUN; // [R12]
							sleep_state_out <= LVL_S0;
							suspend_warning_n_out <= 1'b1;
							button_override_out <= 1'b0;
							wake_event_out <= 1'b1;
						end
					end
					default: begin
						state <= SEQ_RUN;
					end
				endcase
			end
		end
	end

	// ****************************************************
	// plane controls
	// ****************************************************
	// planes follow the committed level one cycle later [R4] [R5] [R6]
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			sleep_ram_plane_off_n_out <= 1'b1;
			sleep_disk_plane_off_n_out <= 1'b1;
			soft_off_plane_off_n_out <= 1'b1;
		end else begin
			sleep_ram_plane_off_n_out <= !(sleep_state_out >= LVL_S3);
			sleep_disk_plane_off_n_out <= !(sleep_state_out >= LVL_S4);
			soft_off_plane_off_n_out <= !(sleep_state_out == LVL_S5);
		end
	end

	// ****************************************************
	// interrupts, throttle, clocks and host reset
	// ****************************************************
	logic therm_irq;
	logic btn_irq;
	// a press during the warning still counts as working
	assign therm_irq = therm_fall; // [R2]
	assign btn_irq = btn_press & (state != SEQ_SLEEP); // [R11]

	// one-cycle event pulses, each source steered to smi or sci
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			system_mgmt_interrupt_n_out <= 1'b1;
			acpi_control_interrupt_out <= 1'b0;
		end else begin
			system_mgmt_interrupt_n_out <= !((therm_irq && thermal_use_smi_in) ||
				(btn_irq && button_use_smi_in));
			acpi_control_interrupt_out <= (therm_irq && !thermal_use_smi_in) ||
				(btn_irq && !button_use_smi_in);
		end
	end

	// level outputs; host reset also covers the forced internal reset
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			clock_throttle_out <= 1'b0;
			suspend_refresh_clock_out <= 1'b0;
			host_bus_reset_n_out <= 1'b0;
		end else begin
			clock_throttle_out <= !therm_n; // [R1]
			suspend_refresh_clock_out <= rtc_lvl; // [R20]
			host_bus_reset_n_out <= pwr_good && internal_reset_n_out; // [R7]
		end
	end

	// ****************************************************
	// checks
	// ****************************************************
	a_throttle_alarm: assert property ( // [R1]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		!therm_n ##1 !therm_n |-> clock_throttle_out)
		else $error("throttle not on while thermal alarm held");
	a_thermal_event: assert property ( // [R2]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		therm_fall |=> (!system_mgmt_interrupt_n_out || acpi_control_interrupt_out))
		else $error("thermal alarm raised no interrupt");
	a_trip_soft_off: assert property ( // [R3]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		!trip_n |=> (sleep_state_out == LVL_S5) ##1 !soft_off_plane_off_n_out)
		else $error("thermal trip did not reach soft off");
	a_ram_plane: assert property ( // [R4]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		##1 (sleep_ram_plane_off_n_out == !($past(sleep_state_out) >= LVL_S3)))
		else $error("ram plane control wrong for sleep level");
	a_disk_plane: assert property ( // [R5]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(sleep_state_out < LVL_S4) |=> sleep_disk_plane_off_n_out)
		else $error("disk plane off outside S4 and S5");
	a_soft_plane: assert property ( // [R6]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(sleep_state_out != LVL_S5) |=> soft_off_plane_off_n_out)
		else $error("soft-off plane off outside S5");
	a_bus_reset_pg: assert property ( // [R7]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		!pwr_good |=> !host_bus_reset_n_out)
		else $error("host bus reset released without power good");
	a_button_request: assert property ( // [R11]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(btn_press && state == SEQ_RUN) |=>
		(!system_mgmt_interrupt_n_out || acpi_control_interrupt_out))
		else $error("button press while working raised no interrupt");
	a_button_wake: assert property ( // [R12]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(btn_press && state == SEQ_SLEEP && trip_n && !hold_rise) |=>
		(wake_event_out && sleep_state_out == LVL_S0))
		else $error("button press while asleep did not wake");
	a_override_s5: assert property ( // [R13]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(hold_rise && trip_n) |=> (button_override_out && sleep_state_out == LVL_S5))
		else $error("long press did not force soft off");
	a_ring_blocked: assert property ( // [R14]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(button_override_out && !btn_press && state == SEQ_SLEEP && ring_press) |=>
		!wake_event_out)
		else $error("ring woke system after override");
	a_reset_idle: assert property ( // [R16]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(reset_req && smbus_idle_in) |=> !internal_reset_n_out ##1 !host_bus_reset_n_out)
		else $error("reset not forced at once on idle smbus");
	a_warn_before: assert property ( // [R19]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		(state == SEQ_WARN && warn_count == WARN_LAST && trip_n && !hold_rise) |->
		!suspend_warning_n_out ##1 (sleep_state_out == target))
		else $error("sleep entered without suspend warning");
	a_refresh_clock: assert property ( // [R20]
		@(posedge clk_sys_in) disable iff (!rst_b_in)
		$rose(rtc_lvl) |=> suspend_refresh_clock_out)
		else $error("suspend refresh clock does not follow rtc");
endmodule

// file: testbench/pmsq_board_model.sv
`timescale 1ns/1ps
module pmsq_board_model
	#(parameter int RTC_HALF_NS = 400)
	(
	output logic rtc_clock_out, // always-running rtc clock
	output logic core_power_good_out // core supply good, async to clk
	);
	// rtc runs free; odd start offset keeps it unrelated to the system clock
	initial begin
		rtc_clock_out = 1'b0;
		#37;
		forever #(RTC_HALF_NS) rtc_clock_out = ~rtc_clock_out;
	end
	// power good only once core power and clock have settled for 1 ms
	initial begin
		core_power_good_out = 1'b0;
		#1_000_000;
		core_power_good_out = 1'b1;
	end
	// supply loss: power good falls at once
	task automatic drop();
		core_power_good_out = 1'b0;
	endtask
	// stays low until the fourth rtc rising edge, holding the host bus in reset meanwhile
	task automatic restore();
		repeat (4) @(posedge rtc_clock_out);
		core_power_good_out = 1'b1;
	endtask
endmodule

// file: testbench/sleep_state_power_sequencer_tb.sv
`timescale 1ns/1ps
module sleep_state_power_sequencer_tb;
	import pmsq_pkg::*;
	localparam int HL = 5;
	logic clk = 1'b0, rst_b = 1'b0, therm_n = 1'b1, trip_n = 1'b1, btn_n = 1'b1;
	logic ring_n = 1'b1, rbtn_n = 1'b1, smb_idle = 1'b1, req = 1'b0, ring_wr = 1'b0;
	logic ring_en = 1'b0, t_smi = 1'b1, b_smi = 1'b1;
	logic [2:0] lvl_in = 3'h0;
	wire rtc, pg, ram_n, disk_n, off_n, warn_n, sclk, hbr_n, smi_n, acpi_control_interrupt, thr, irst_n, wake, ovr;
	wire [2:0] st;
	int seed = 32'hfbe6_8ffb;
	int miscompares = 0, n_checks = 0, i, a, b, c;
	int n_smi = 0, n_sci = 0, n_wake = 0, n_irst = 0, n_sclk = 0, n_rtc = 0;
	logic p_irst = 1'b1, p_sclk = 1'b0, p_rtc = 1'b0;
	logic [2:0] lvl;

	always #50 clk = ~clk;

	pmsq_board_model u_pmsq_board_model (.rtc_clock_out(rtc), .core_power_good_out(pg));

	pmsq_sequencer #(.SMB_WAIT_CYCLES(20), .HOLD_LIMIT(HL), .DEBOUNCE_LIMIT(3)) u_pmsq_sequencer (
		.clk_sys_in(clk), .rst_b_in(rst_b), .thermal_alarm_n_in(therm_n),
		.thermal_trip_n_in(trip_n), .power_button_n_in(btn_n), .ring_indicate_n_in(ring_n),
		.reset_button_n_in(rbtn_n), .core_power_good_in(pg), .rtc_clock_in(rtc),
		.smbus_idle_in(smb_idle), .sleep_request_in(req), .sleep_level_in(lvl_in),
		.ring_wake_enable_wr_in(ring_wr), .ring_wake_enable_in(ring_en),
		.thermal_use_smi_in(t_smi), .button_use_smi_in(b_smi),
		.sleep_ram_plane_off_n_out(ram_n), .sleep_disk_plane_off_n_out(disk_n),
		.soft_off_plane_off_n_out(off_n), .suspend_warning_n_out(warn_n),
		.suspend_refresh_clock_out(sclk), .host_bus_reset_n_out(hbr_n),
		.system_mgmt_interrupt_n_out(smi_n), .acpi_control_interrupt_out(acpi_control_interrupt),
		.clock_throttle_out(thr), .internal_reset_n_out(irst_n), .wake_event_out(wake),
		.sleep_state_out(st), .button_override_out(ovr));

	// pulses last one cycle, so events are tallied at every edge
	always @(posedge clk) begin
		n_smi <= n_smi + int'(smi_n === 1'b0);
		n_sci <= n_sci + int'(acpi_control_interrupt === 1'b1);
		n_wake <= n_wake + int'(wake === 1'b1);
		n_irst <= n_irst + int'(p_irst && irst_n === 1'b0);
		n_sclk <= n_sclk + int'(!p_sclk && sclk === 1'b1);
		n_rtc <= n_rtc + int'(!p_rtc && rtc);
		p_irst <= irst_n;
		p_sclk <= sclk;
		p_rtc <= rtc;
	end

	// ****************************************************
	// helpers
	// ****************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// plane controls, active low, for a given level
	function automatic logic [7:0] exp_planes(input logic [2:0] l);
		return {5'h00, l < 3'h3, l < 3'h4, l != 3'h5};
	endfunction
	task automatic press(input int n);
		btn_n = 1'b0;
		cyc(n);
		btn_n = 1'b1;
		cyc(8);
	endtask
	task automatic go_sleep(input logic [2:0] l);
		req = 1'b1;
		lvl_in = l;
		cyc(1);
		req = 1'b0;
		cyc(2);
		chk(8'(warn_n), 8'h00);
		chk(8'(st), 8'h00);
		cyc(WARN_CYC + 1);
		chk(8'(st), 8'(l));
		chk({5'h00, ram_n, disk_n, off_n}, exp_planes(l));
	endtask
	task automatic wake_btn();
		a = n_wake;
		press(4);
		chk(8'(n_wake - a), 8'h01);
		chk({4'h0, ovr, ram_n, disk_n, off_n}, 8'h07);
	endtask
	task automatic ring_pulse();
		ring_n = 1'b0;
		cyc(6);
		ring_n = 1'b1;
		cyc(4);
	endtask
	task automatic set_ring(input logic v);
		ring_en = v;
		ring_wr = 1'b1;
		cyc(1);
		ring_wr = 1'b0;
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// a full run stops well short of this
	initial begin
		cyc(40000);
		miscompares++;
		conclude();
	end

	// ****************************************************
	// main sequence
	// ****************************************************
	initial begin
		cyc(5);
		// resume power counts as settled once this reset lifts
		rst_b = 1'b1;
		wait (pg === 1'b1);
		cyc(6);
		chk(8'(hbr_n), 8'h01);
		// thermal alarm, both interrupt routes
		for (i = 0; i < 4; i++) begin
			t_smi = i[0];
			a = n_smi;
			b = n_sci;
			therm_n = 1'b0;
			cyc(4);
			chk(8'(thr), 8'h01);
			chk(8'(n_smi - a), 8'(i[0]));
			chk(8'(n_sci - b), 8'(!i[0]));
			therm_n = 1'b1;
			cyc(4);
			chk(8'(thr), 8'h00);
		end
		// button while working is a sleep request, not a wake
		for (i = 0; i < 2; i++) begin
			b_smi = 1'($random(seed));
			a = n_smi;
			b = n_sci;
			c = n_wake;
			press(4);
			chk(8'(n_smi - a), 8'(b_smi));
			chk(8'(n_sci - b), 8'(!b_smi));
			chk(8'(n_wake - c), 8'h00);
		end
		// every plane level, then random ones
		for (i = 0; i < 6; i++) begin
			lvl = (i < 3) ? 3'(i + 3) : 3'($unsigned($random(seed)) % 5 + 1);
			go_sleep(lvl);
			wake_btn();
		end
		// ring enable survives a power failure
		set_ring(1'b1);
		u_pmsq_board_model.drop();
		cyc(5);
		chk(8'(hbr_n), 8'h00);
		u_pmsq_board_model.restore();
		cyc(6);
		chk(8'(hbr_n), 8'h01);
		go_sleep(3'h3);
		ring_pulse();
		chk(8'(st), 8'h00);
		set_ring(1'b0);
		go_sleep(3'h4);
		ring_pulse();
		chk(8'(st), 8'h04);
		wake_btn();
		// long press from S3 forces soft-off; then ring cannot wake
		set_ring(1'b1);
		go_sleep(3'h3);
		press(HL * 8 + 30);
		chk({4'h0, ovr, st}, 8'h0d);
		ring_pulse();
		chk(8'(st), 8'h05);
		wake_btn();
		// thermal trip goes straight to soft-off
		trip_n = 1'b0;
		cyc(5);
		chk({4'h0, off_n, st}, 8'h05);
		trip_n = 1'b1;
		cyc(4);
		wake_btn();
		// reset button: glitch ignored, then busy and idle smbus
		a = n_irst;
		rbtn_n = 1'b0;
		cyc(5);
		rbtn_n = 1'b1;
		cyc(60);
		chk(8'(n_irst - a), 8'h00);
		for (i = 0; i < 2; i++) begin
			smb_idle = i[0];
			a = n_irst;
			rbtn_n = 1'b0;
			cyc(40);
			rbtn_n = 1'b1;
			cyc(80);
			chk(8'(n_irst - a), 8'h01);
		end
		chk(8'(n_rtc - n_sclk <= 1 && n_sclk > 10), 8'h01);
		conclude();
	end
endmodule
